/* File: pkg/wotbr_pkg.sv */
package wotbr_pkg;

    // ----------------------------------------------------------------
    // Serial command frame layout
    // ----------------------------------------------------------------
    localparam int          FRAME_BITS  = 32;           // Bits in one command
    localparam int          ADDR_W      = 7;            // Register address width
    localparam int          ADDR_HI     = 6;            // Address top bit in frame
    localparam int          MODE_BIT    = 7;            // Access mode, 1 = write
    localparam int          DATA_LO     = 8;            // First data bit in frame
    localparam int          DATA_HI     = 23;           // Last data bit in frame
    localparam int          DATA_W      = 16;           // Register width
    localparam logic [7:0]  STATUS_BYTE = 8'h00;        // Byte returned in bits 7:0
    localparam logic [7:0]  CHECK_BYTE  = 8'h00;        // Byte returned in bits 31:24

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [6:0]  ADDR_OSC_TRIM = 7'h3C;      // Wake oscillator trim control
    localparam logic [6:0]  ADDR_OSC_CAL  = 7'h3D;      // Wake oscillator calibration status
    localparam logic [6:0]  ADDR_CDR      = 7'h3E;      // Bit recovery control

    // ----------------------------------------------------------------
    // Oscillator trim register fields
    // ----------------------------------------------------------------
    localparam int          RXSEL_BIT   = 14;           // Wake receiver select
    localparam int          TCOEF_HI    = 11;           // Temperature coefficient trim
    localparam int          TCOEF_LO    = 7;
    localparam int          CTRIM_HI    = 6;            // Oscillator coarse trim
    localparam int          CTRIM_LO    = 0;
    localparam logic [15:0] TRIM_RST    = 16'h0000;     // Power-on / soft reset value
    localparam logic [15:0] TRIM_MASK   = 16'h4FFF;     // Implemented bits
    localparam logic [1:0]  TRIM_UNLOCK = 2'h3;         // Unlock code for trim writes

    // ----------------------------------------------------------------
    // Calibration register fields
    // ----------------------------------------------------------------
    localparam int          CALH_HI     = 15;
    localparam int          CALH_LO     = 8;
    localparam int          CALL_HI     = 7;
    localparam int          CALL_LO     = 0;
    localparam logic [15:0] CAL_RST     = 16'h0000;

    // ----------------------------------------------------------------
    // Bit recovery control fields
    // ----------------------------------------------------------------
    localparam int          CLKSEL_HI   = 6;            // Recovery clock select
    localparam int          CLKSEL_LO   = 5;
    localparam int          FILT_HI     = 3;            // Filter time constant code
    localparam int          FILT_LO     = 2;
    localparam int          EN_BIT      = 0;            // Recovery enable
    localparam logic [15:0] CDR_RST     = 16'h0004;     // Constant 16, disabled
    localparam logic [15:0] CDR_MASK    = 16'h006D;     // Implemented bits
    localparam logic [3:0]  DIV_BASE    = 4'h1;         // 75 MHz divided by 2^select

    // ----------------------------------------------------------------
    // Filter codes, constants and adaptive gap bands in bit times
    // ----------------------------------------------------------------
    localparam logic [1:0]  FILT_C8     = 2'h0;
    localparam logic [1:0]  FILT_C16    = 2'h1;
    localparam logic [1:0]  FILT_C32    = 2'h2;
    localparam logic [1:0]  FILT_ADAPT  = 2'h3;
    localparam logic [5:0]  TC_8        = 6'h08;
    localparam logic [5:0]  TC_16       = 6'h10;
    localparam logic [5:0]  TC_32       = 6'h20;
    localparam logic [3:0]  GAP_MIN32   = 4'h2;
    localparam logic [3:0]  GAP_MAX32   = 4'h3;
    localparam logic [3:0]  GAP_MIN16   = 4'h4;
    localparam logic [3:0]  GAP_MAX16   = 4'h8;
    localparam logic [3:0]  GAP_MIN8    = 4'h9;
    localparam logic [3:0]  GAP_MAX8    = 4'hA;
    localparam logic [3:0]  GAP_SAT     = 4'hF;

    // ----------------------------------------------------------------
    // Serial frame states
    // ----------------------------------------------------------------
    typedef enum logic {
        SPI_IDLE,
        SPI_SHIFT
    } wotbr_spi_state_e;

endpackage

/* File: src/wotbr_spi_frame.sv */
`timescale 1ns/10ps
module wotbr_spi_frame
(
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    // Serial pins
    input  wire logic                        i_csn_b,
    input  wire logic                        i_sclk,
    input  wire logic                        i_sdi,
    output logic                             o_sdo,
    // Register side
    input  wire logic [wotbr_pkg::DATA_W-1:0] i_rdata,
    output logic [wotbr_pkg::ADDR_W-1:0]     o_addr,
    output logic                             o_write,
    output logic [wotbr_pkg::DATA_W-1:0]     o_wdata,
    output logic                             o_frame_done
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    wotbr_pkg::wotbr_spi_state_e      state_reg, state_next;   // Frame state
    logic [5:0]                       cnt_reg, cnt_next;       // Bits taken
    logic [wotbr_pkg::FRAME_BITS-1:0] frame_reg, frame_next;   // Bits by index
    logic [wotbr_pkg::FRAME_BITS-1:0] reply_reg, reply_next;   // Reply bits
    logic                             sdo_reg, sdo_next;       // Output bit
    logic                             done_reg, done_next;     // Frame pulse
    logic                             sclk_reg;                // Last clock level
    logic                             rise, fall;              // Clock edges
    logic                             in_frame;                // Room for bits

    assign rise     = i_sclk & ~sclk_reg;
    assign fall     = ~i_sclk & sclk_reg;
    assign in_frame = (cnt_reg < 6'(wotbr_pkg::FRAME_BITS));

    // Frame fields from the captured bits, first bit is bit 0
    assign o_addr       = frame_reg[wotbr_pkg::ADDR_HI:0];
    assign o_write      = frame_reg[wotbr_pkg::MODE_BIT];
    assign o_wdata      = frame_reg[wotbr_pkg::DATA_HI:wotbr_pkg::DATA_LO];
    assign o_frame_done = done_reg;
    assign o_sdo        = sdo_reg;

    // ----------------------------------------------------------------
    // Frame sequencing
    // ----------------------------------------------------------------
    // Next values of the shifter
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        frame_next = frame_reg;
        reply_next = reply_reg;
        sdo_next   = sdo_reg;
        done_next  = 1'b0;
        case (state_reg)
            wotbr_pkg::SPI_IDLE:
            begin
                // Select falls: fresh frame, status bits first
                if (!i_csn_b)
                begin
                    state_next = wotbr_pkg::SPI_SHIFT;
                    cnt_next   = '0;
                    reply_next = {wotbr_pkg::CHECK_BYTE, 16'h0000, wotbr_pkg::STATUS_BYTE};
                    sdo_next   = wotbr_pkg::STATUS_BYTE[0];
                end
            end
            wotbr_pkg::SPI_SHIFT:
            begin
                if (i_csn_b)
                begin
                    // Only a whole 32-bit frame is acted on
                    state_next = wotbr_pkg::SPI_IDLE;
                    done_next  = (cnt_reg == 6'(wotbr_pkg::FRAME_BITS));
                end
                else
                begin
                    // Sample on rising clock
                    if (rise && in_frame)
                    begin
                        frame_next[cnt_reg[4:0]] = i_sdi;
                        cnt_next = cnt_reg + 6'h01;
                    end
                    // Shift out on falling clock, register read once address is in
                    if (fall && in_frame)
                    begin
                        if (cnt_reg == 6'(wotbr_pkg::DATA_LO))
                        begin
                            reply_next[wotbr_pkg::DATA_HI:wotbr_pkg::DATA_LO] = i_rdata;
                            sdo_next = i_rdata[0];
                        end
                        else
                        begin
                            sdo_next = reply_reg[cnt_reg[4:0]];
                        end
                    end
                end
            end
            default:
            begin
                state_next = wotbr_pkg::SPI_IDLE;
            end
        endcase
    end

    // Register stage
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= wotbr_pkg::SPI_IDLE;
            cnt_reg   <= '0;
            frame_reg <= '0;
            reply_reg <= '0;
            sdo_reg   <= 1'b0;
            done_reg  <= 1'b0;
            sclk_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            frame_reg <= frame_next;
            reply_reg <= reply_next;
            sdo_reg   <= sdo_next;
            done_reg  <= done_next;
            sclk_reg  <= i_sclk;
        end
    end

endmodule

/* File: src/wotbr_filter_sel.sv */
`timescale 1ns/10ps
module wotbr_filter_sel
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_enable,
    input  wire logic [1:0] i_filter_code,
    // Bus activity
    input  wire logic       i_rx_data,
    input  wire logic       i_bit_tick,
    // Result
    output logic [5:0]      o_time_constant
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [3:0] gap_reg, gap_next;   // Bit times since last falling edge
    logic [5:0] tc_reg, tc_next;     // Selected time constant
    logic       rx_reg;              // Last receive level
    logic       falling;             // Falling edge on receive

    assign falling         = rx_reg & ~i_rx_data;
    assign o_time_constant = tc_reg;

    // ----------------------------------------------------------------
    // Constant selection
    // ----------------------------------------------------------------
    // Next gap count and constant
    always_comb
    begin
        gap_next = gap_reg;
        tc_next  = tc_reg;
        // Gap counter, held at zero while recovery is off
        if (!i_enable || falling)
            gap_next = '0;
        else if (i_bit_tick && gap_reg != wotbr_pkg::GAP_SAT)
            gap_next = gap_reg + 4'h1;
        case (i_filter_code)
            wotbr_pkg::FILT_C8:  tc_next = wotbr_pkg::TC_8;
            wotbr_pkg::FILT_C16: tc_next = wotbr_pkg::TC_16;
            wotbr_pkg::FILT_C32: tc_next = wotbr_pkg::TC_32;
            wotbr_pkg::FILT_ADAPT:
            begin
                // Banded by edge spacing, out-of-band gaps keep the last value
                if (i_enable && falling)
                begin
                    if (gap_reg >= wotbr_pkg::GAP_MIN32 && gap_reg <= wotbr_pkg::GAP_MAX32)
                        tc_next = wotbr_pkg::TC_32;
                    else if (gap_reg >= wotbr_pkg::GAP_MIN16 && gap_reg <= wotbr_pkg::GAP_MAX16)
                        tc_next = wotbr_pkg::TC_16;
                    else if (gap_reg >= wotbr_pkg::GAP_MIN8 && gap_reg <= wotbr_pkg::GAP_MAX8)
                        tc_next = wotbr_pkg::TC_8;
                end
            end
            default:
            begin
                tc_next = wotbr_pkg::TC_16;
            end
        endcase
    end

    // Register stage
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            gap_reg <= '0;
            tc_reg  <= wotbr_pkg::TC_16;
            rx_reg  <= 1'b1;
        end
        else
        begin
            gap_reg <= gap_next;
            tc_reg  <= tc_next;
            rx_reg  <= i_rx_data;
        end
    end

endmodule

/* File: src/wotbr_cfg.sv */
// Function
// - Reserved bits always read back zero
// - Bit 14 picks low-power or standard receiver
// - Trim fields writable only with unlock 11
// - Temp coefficient 11:7, coarse trim 6:0
// - Receiver select resets to low-power receiver
// - Reset clears trim; restart zeroes reserved only
// - Calibration high byte 15:8, low 7:0
// - Clock select 6:5 picks 75 MHz halvings
// - Filter code 3:2 gives constants 8/16/32
// - Code 11 adapts constant to edge spacing
// - Bit 0 enables bit clock recovery
// - Restart zeroes recovery reserved bits, keeps fields
// - Access by four-byte 32-bit serial command
`timescale 1ns/10ps
module wotbr_cfg
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_soft_rst,
    input  wire logic        i_restart,
    // Serial command pins
    input  wire logic        i_spi_csn_b,
    input  wire logic        i_spi_sclk,
    input  wire logic        i_spi_sdi,
    output logic             o_spi_sdo,
    // Trim unlock and calibration source
    input  wire logic [1:0]  i_trim_unlock,
    input  wire logic [15:0] i_calibration,
    // Bus activity for recovery
    input  wire logic        i_rx_data,
    input  wire logic        i_bit_tick,
    // Oscillator trim outputs
    output logic             o_wake_receiver_select,
    output logic [4:0]       o_temp_coef_trim,
    output logic [6:0]       o_oscillator_coarse_trim,
    // Bit clock recovery outputs
    output logic [1:0]       o_recovery_clock_select,
    output logic [3:0]       o_recovery_clock_div,
    output logic             o_recovery_enable,
    output logic [5:0]       o_filter_time_constant
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic        rst_meta_reg;             // Reset release, first stage
    logic        rst_n_reg;                // Reset release, used copy
    logic [15:0] trim_reg, trim_next;      // Oscillator trim control
    logic [15:0] cdr_reg, cdr_next;        // Bit recovery control
    logic [15:0] cal_reg, cal_next;        // Calibration status
    logic        rxsel_reg;                // Receiver select output
    logic [4:0]  tcoef_reg;                // Temp coefficient output
    logic [6:0]  ctrim_reg;                // Coarse trim output
    logic [1:0]  clksel_reg;               // Clock select output
    logic [3:0]  div_reg;                  // Clock divide output
    logic        en_reg;                   // Enable output
    logic [6:0]  cmd_addr;                 // Address of current frame
    logic        cmd_write;                // Frame is a write
    logic [15:0] cmd_wdata;                // Frame data
    logic        cmd_done;                 // Whole frame received
    logic [15:0] rd_value;                 // Read mux result

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Read view of an address, unmapped reads zero
    function automatic logic [15:0] read_reg(input logic [6:0] addr, input logic [15:0] trim,
                                             input logic [15:0] cal, input logic [15:0] bit_clock_recovery);
        case (addr)
            wotbr_pkg::ADDR_OSC_TRIM: read_reg = trim & wotbr_pkg::TRIM_MASK;
            wotbr_pkg::ADDR_OSC_CAL:  read_reg = cal;
            wotbr_pkg::ADDR_CDR:      read_reg = bit_clock_recovery & wotbr_pkg::CDR_MASK;
            default:                  read_reg = 16'h0000;
        endcase
    endfunction

    // Divide ratio from 75 MHz for a clock select code
    function automatic logic [3:0] clk_div(input logic [1:0] sel);
        clk_div = 4'(wotbr_pkg::DIV_BASE << sel);
    endfunction

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    // Two-stage release of the asynchronous reset
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Serial command front end
    // ----------------------------------------------------------------
    // Read data follows the address bits of the frame
    assign rd_value = read_reg(cmd_addr, trim_reg, cal_reg, cdr_reg);

    // Four-byte command shifter
    wotbr_spi_frame u_spi
    (
        .i_clk        (i_ref_clk),
        .i_rst_n      (rst_n_reg),
        .i_csn_b      (i_spi_csn_b),
        .i_sclk       (i_spi_sclk),
        .i_sdi        (i_spi_sdi),
        .o_sdo        (o_spi_sdo),
        .i_rdata      (rd_value),
        .o_addr       (cmd_addr),
        .o_write      (cmd_write),
        .o_wdata      (cmd_wdata),
        .o_frame_done (cmd_done)
    );

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // Next register values
    always_comb
    begin
        trim_next = trim_reg;
        cdr_next  = cdr_reg;
        cal_next  = i_calibration;   // Status tracks the calibration source
        if (i_soft_rst)
        begin
            // Soft reset loads the defined values
            trim_next = wotbr_pkg::TRIM_RST;
            cdr_next  = wotbr_pkg::CDR_RST;
            cal_next  = wotbr_pkg::CAL_RST;
        end
        else if (i_restart)
        begin
            // Restart clears reserved bits, configurable fields keep their value
            trim_next = trim_reg & wotbr_pkg::TRIM_MASK;
            cdr_next  = cdr_reg & wotbr_pkg::CDR_MASK;
        end
        else if (cmd_done && cmd_write)
        begin
            case (cmd_addr)
                wotbr_pkg::ADDR_OSC_TRIM:
                begin
                    // Locked trim ignores writes
                    if (i_trim_unlock == wotbr_pkg::TRIM_UNLOCK)
                        trim_next = cmd_wdata & wotbr_pkg::TRIM_MASK;
                end
                wotbr_pkg::ADDR_CDR:
                begin
                    cdr_next = cmd_wdata & wotbr_pkg::CDR_MASK;
                end
                default:
                begin
                    // Calibration and unmapped addresses take no write
                    trim_next = trim_reg;
                end
            endcase
        end
    end

    // Register stage, including field outputs
    always_ff @(posedge i_ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            trim_reg   <= wotbr_pkg::TRIM_RST;
            cdr_reg    <= wotbr_pkg::CDR_RST;
            cal_reg    <= wotbr_pkg::CAL_RST;
            rxsel_reg  <= 1'b0;
            tcoef_reg  <= '0;
            ctrim_reg  <= '0;
            clksel_reg <= '0;
            div_reg    <= wotbr_pkg::DIV_BASE;
            en_reg     <= 1'b0;
        end
        else
        begin
            trim_reg   <= trim_next;
            cdr_reg    <= cdr_next;
            cal_reg    <= cal_next;
            // Field outputs from the stored registers
            rxsel_reg  <= trim_reg[wotbr_pkg::RXSEL_BIT];
            tcoef_reg  <= trim_reg[wotbr_pkg::TCOEF_HI:wotbr_pkg::TCOEF_LO];
            ctrim_reg  <= trim_reg[wotbr_pkg::CTRIM_HI:wotbr_pkg::CTRIM_LO];
            // Recovery clock choice
            clksel_reg <= cdr_reg[wotbr_pkg::CLKSEL_HI:wotbr_pkg::CLKSEL_LO];
            div_reg    <= clk_div(cdr_reg[wotbr_pkg::CLKSEL_HI:wotbr_pkg::CLKSEL_LO]);
            en_reg     <= cdr_reg[wotbr_pkg::EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Filter time constant
    // ----------------------------------------------------------------
    // Fixed or adaptive constant from the filter code
    wotbr_filter_sel u_filter
    (
        .i_clk           (i_ref_clk),
        .i_rst_n         (rst_n_reg),
        .i_enable        (cdr_reg[wotbr_pkg::EN_BIT]),
        .i_filter_code   (cdr_reg[wotbr_pkg::FILT_HI:wotbr_pkg::FILT_LO]),
        .i_rx_data       (i_rx_data),
        .i_bit_tick      (i_bit_tick),
        .o_time_constant (o_filter_time_constant)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_wake_receiver_select   = rxsel_reg;
    assign o_temp_coef_trim         = tcoef_reg;
    assign o_oscillator_coarse_trim = ctrim_reg;
    assign o_recovery_clock_select  = clksel_reg;
    assign o_recovery_clock_div     = div_reg;
    assign o_recovery_enable        = en_reg;

endmodule

/* File: tb/wotbr_cfg_properties.sv */
`timescale 1ns/10ps
module wotbr_cfg_properties
(
    // Watched ports
    input wire logic       i_ref_clk, i_rst_b, i_soft_rst, o_wake_receiver_select, o_recovery_enable,
    input wire logic [1:0] i_trim_unlock, o_recovery_clock_select,
    input wire logic [4:0] o_temp_coef_trim,
    input wire logic [6:0] o_oscillator_coarse_trim,
    input wire logic [3:0] o_recovery_clock_div,
    input wire logic [5:0] o_filter_time_constant
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // Soft reset two edges back: loaded, then passed to the outputs
    sequence s_soft; i_soft_rst ##2 1'b1; endsequence
    // Trim outputs may move only after an unlocked write or a soft reset
    sequence s_may; $past(i_trim_unlock, 2) == 2'h3 || $past(i_soft_rst, 2); endsequence
    a_div_tracks_sel: assert property (o_recovery_clock_div == 4'h1 << o_recovery_clock_select)
        else $error("divider mismatch");
    a_const_legal: assert property (o_filter_time_constant inside {6'h08, 6'h10, 6'h20})
        else $error("bad constant");
    a_soft_rxsel_low: assert property (s_soft |-> !o_wake_receiver_select)
        else $error("receiver not low-power");
    a_soft_trim_clear: assert property (s_soft |-> !o_temp_coef_trim && !o_oscillator_coarse_trim)
        else $error("trim not cleared");
    a_soft_rec_init: assert property (s_soft |-> !o_recovery_enable && o_filter_time_constant == 6'h10)
        else $error("recovery not reset");
    a_rxsel_locked: assert property ($changed(o_wake_receiver_select) |-> s_may)
        else $error("locked receiver moved");
    a_coef_locked: assert property ($changed(o_temp_coef_trim) |-> s_may)
        else $error("locked coefficient moved");
    a_coarse_locked: assert property ($changed(o_oscillator_coarse_trim) |-> s_may)
        else $error("locked coarse trim moved");
endmodule
bind wotbr_cfg wotbr_cfg_properties u_props (.*);

/* File: tb/wotbr_host.sv */
`timescale 1ns/10ps
module wotbr_host
(
    input  wire logic i_clk,
    input  wire logic i_sdo,
    output logic      o_csn_b, o_sclk, o_sdi
);
    initial {o_csn_b, o_sclk, o_sdi} = 3'b100;
    // One four-byte command, first bit first; reply bits 23:8 returned
    task automatic xfer(input logic [31:0] cmd, output logic [15:0] rd);
        logic [31:0] rx;
        @(posedge i_clk) #1 o_csn_b = 1'b0;
        for (int b = 0; b < 32; b++)
        begin
            o_sdi = cmd[b];
            repeat (2) @(posedge i_clk);
            rx[b] = i_sdo;
            #1 o_sclk = 1'b1;
            repeat (2) @(posedge i_clk);
            #1 o_sclk = 1'b0;
        end
        repeat (2) @(posedge i_clk);
        #1 o_csn_b = 1'b1;
        o_sdi = ~o_sdi;
        rd = rx[23:8];
    endtask
endmodule

/* File: tb/wotbr_cfg_tb.sv */
`timescale 1ns/10ps
module wotbr_cfg_tb;
    logic i_ref_clk = 0, i_rst_b = 0, i_soft_rst = 0, i_restart = 0, i_rx_data = 0, i_bit_tick = 0;
    logic i_spi_csn_b, i_spi_sclk, i_spi_sdi, o_spi_sdo, o_wake_receiver_select, o_recovery_enable;
    logic [1:0] i_trim_unlock = 2'h2, o_recovery_clock_select;
    logic [15:0] i_calibration = 16'h0000, rd, v;
    logic [4:0] o_temp_coef_trim;
    logic [6:0] o_oscillator_coarse_trim;
    logic [3:0] o_recovery_clock_div;
    logic [5:0] o_filter_time_constant;
    int errors = 0, comparisons = 0, seed = 38;
    always #5 i_ref_clk = ~i_ref_clk;
    // Random bus activity for the adaptive filter
    always @(posedge i_ref_clk) #1 {i_rx_data, i_bit_tick} <= 2'($random(seed));
    wotbr_cfg uut (.*);
    wotbr_host host (.i_clk(i_ref_clk), .i_sdo(o_spi_sdo), .o_csn_b(i_spi_csn_b),
        .o_sclk(i_spi_sclk), .o_sdi(i_spi_sdi));
    // Packed field outputs
    wire [15:0] trim_out = {3'h0, o_wake_receiver_select, o_temp_coef_trim, o_oscillator_coarse_trim};
    wire [15:0] rec_out  = {o_recovery_clock_div, o_filter_time_constant, o_recovery_enable};
    task automatic check(input string what, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic wr, input logic [6:0] a, input logic [15:0] d);
        host.xfer({8'h00, d, wr, a}, rd);
        repeat (4) @(posedge i_ref_clk);
        #1;
    endtask
    // Divider, constant and enable expected from a control word
    function automatic logic [15:0] rec_exp(input logic [15:0] w);
        return {5'h00, 4'h1 << w[6:5], 6'h08 << w[3:2], w[0]};
    endfunction
    // Adaptive constant model
    function automatic logic [5:0] band(int g, logic [5:0] old);
        return g inside {[2:3]} ? 6'h20 : g inside {[4:8]} ? 6'h10 : g inside {[9:10]} ? 6'h08 : old;
    endfunction
    logic rx_m = 1, adapt = 0, sync = 0;
    logic [5:0] tc_m = 6'h00;
    int gap_m = 0;
    always @(posedge i_ref_clk)
    begin
        rx_m <= i_rx_data;
        gap_m <= (rx_m && !i_rx_data) ? 0 : gap_m + int'(i_bit_tick && gap_m < 15);
        if (rx_m && !i_rx_data) {sync, tc_m} <= {adapt, sync ? band(gap_m, tc_m) : tc_m};
    end
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin #200us; errors++; wrap_up; end
    initial
    begin
        repeat (6) @(posedge i_ref_clk);
        #1 i_rst_b = 1;
        i_calibration = 16'($random(seed));
        repeat (3) @(posedge i_ref_clk);
        acc(0, wotbr_pkg::ADDR_OSC_TRIM, 0); check("trim", rd, 16'h0000);
        acc(0, wotbr_pkg::ADDR_CDR, 0); check("recovery", rd, 16'h0004);
        acc(1, wotbr_pkg::ADDR_OSC_CAL, ~i_calibration);
        acc(0, wotbr_pkg::ADDR_OSC_CAL, 0); check("calibration", rd, i_calibration);
        acc(0, 7'h10, 0); check("unmapped", rd, 16'h0000);
        acc(1, wotbr_pkg::ADDR_OSC_TRIM, 16'hFFFF);
        acc(0, wotbr_pkg::ADDR_OSC_TRIM, 0); check("locked trim", rd, 16'h0000);
        i_trim_unlock = 2'h3;
        acc(1, wotbr_pkg::ADDR_OSC_TRIM, 16'hFFFF); // Unlocked write of all trim fields
        check("trim outputs", trim_out, 16'h1FFF);
        i_restart = 1;
        @(posedge i_ref_clk) #1 i_restart = 0;
        acc(0, wotbr_pkg::ADDR_OSC_TRIM, 0); check("trim after restart", rd, 16'h4FFF);
        for (int k = 0; k < 12; k++)
        begin
            v = 16'($random(seed));
            v[6:5] = k[1:0];
            v[3:2] = 2'(k % 3);
            acc(1, wotbr_pkg::ADDR_CDR, v);
            check("recovery outputs", rec_out, rec_exp(v));
            acc(0, wotbr_pkg::ADDR_CDR, 0); check("recovery", rd, v & 16'h006D);
        end
        acc(1, wotbr_pkg::ADDR_CDR, 16'h000D);
        acc(0, wotbr_pkg::ADDR_CDR, 0); check("adaptive", rd, 16'h000D);
        adapt = 1;
        repeat (300) @(posedge i_ref_clk) #1
            if (tc_m != 6'h00) check("adaptive constant", o_filter_time_constant, tc_m);
        i_soft_rst = 1;
        repeat (2) @(posedge i_ref_clk);
        #1 i_soft_rst = 0;
        repeat (2) @(posedge i_ref_clk);
        #1;
        check("receiver", o_wake_receiver_select, 16'h0000);
        check("recovery outputs", rec_out, rec_exp(16'h0004));
        acc(0, wotbr_pkg::ADDR_OSC_TRIM, 0); check("trim", rd, 16'h0000);
        wrap_up;
    end
endmodule
